/* File: include/bsr_pkg.sv */
`default_nettype none
package bsr_pkg;
  localparam int START_BITS = 3;
  localparam int SEL_BITS = 4;
  localparam int STOP_BITS = 3;
  localparam int ACK_CLKS = 2;
  localparam int READ_CLKS = 17;
  localparam int WORD_BITS = 16;
  localparam int RESET_BITS = 21;
  localparam int CALIB_BITS = 64;
  localparam int CAL_WORDS = CALIB_BITS / WORD_BITS;
  localparam int BCNT_W = 5;
  localparam int FIFO_DEPTH = 16;
  localparam logic [START_BITS-1:0] START_FIELD = 3'h7;
  localparam logic [STOP_BITS-1:0] STOP_FIELD = 3'h0;
  localparam logic [RESET_BITS-1:0] RESET_PATTERN = 21'h155540;
  localparam logic [SEL_BITS-1:0] SEL_PRESS = 4'ha;
  localparam logic [SEL_BITS-1:0] SEL_TEMP = 4'h9;
  localparam logic [SEL_BITS-1:0] SEL_CAL0 = 4'h5;
  localparam logic [SEL_BITS-1:0] SEL_CAL1 = 4'h6;
  localparam logic [SEL_BITS-1:0] SEL_CAL2 = 4'h3;
  localparam logic [SEL_BITS-1:0] SEL_CAL3 = 4'hc;
  // arbitrary factory content, replaced per part
  localparam logic [CALIB_BITS-1:0] CALIB_DEFAULT = 64'h0123_4567_89ab_cdef;
  localparam int CLK_PERIOD_NS = 100;
  localparam int CONV_TIME_NS = 35_000_000;
  localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int CONV_W = $clog2(CONV_CYCLES + 1);
  localparam int SCLK_HALF_NS = 800;
  localparam int SCLK_HALF_CYCLES = SCLK_HALF_NS / CLK_PERIOD_NS;
  localparam logic [BCNT_W-1:0] START_LAST = BCNT_W'(START_BITS - 1);
  localparam logic [BCNT_W-1:0] SEL_LAST = BCNT_W'(SEL_BITS - 1);
  localparam logic [BCNT_W-1:0] STOP_LAST = BCNT_W'(STOP_BITS - 1);
  localparam logic [BCNT_W-1:0] ACK_LAST = BCNT_W'(ACK_CLKS - 1);
  localparam logic [BCNT_W-1:0] READ_LAST = BCNT_W'(READ_CLKS - 1);
  localparam logic [BCNT_W-1:0] FRAME_CLKS = BCNT_W'(START_BITS + SEL_BITS + STOP_BITS);
  localparam logic [BCNT_W-1:0] CONV_FRAME_CLKS = BCNT_W'(START_BITS + SEL_BITS + STOP_BITS + ACK_CLKS);
  localparam logic [BCNT_W-1:0] RESET_CLKS = BCNT_W'(RESET_BITS);
  localparam logic [BCNT_W-1:0] READ_CLKS_W = BCNT_W'(READ_CLKS);

  typedef enum logic [2:0] {
    OP_PRESS = 3'h0,
    OP_TEMP = 3'h1,
    OP_CAL0 = 3'h2,
    OP_CAL1 = 3'h3,
    OP_CAL2 = 3'h4,
    OP_CAL3 = 3'h5,
    OP_RESET = 3'h6
  } bsr_op_t;

  function automatic logic sel_is_conv(input logic [SEL_BITS-1:0] sel);
    sel_is_conv = (sel == SEL_PRESS) || (sel == SEL_TEMP);
  endfunction

  function automatic logic sel_is_cal(input logic [SEL_BITS-1:0] sel);
    sel_is_cal = (sel == SEL_CAL0) || (sel == SEL_CAL1) || (sel == SEL_CAL2) || (sel == SEL_CAL3);
  endfunction

  function automatic logic [1:0] sel_cal_index(input logic [SEL_BITS-1:0] sel);
    if (sel == SEL_CAL0)
      sel_cal_index = 2'h0;
    else if (sel == SEL_CAL1)
      sel_cal_index = 2'h1;
    else if (sel == SEL_CAL2)
      sel_cal_index = 2'h2;
    else
      sel_cal_index = 2'h3;
  endfunction

  function automatic logic [SEL_BITS-1:0] op_sel(input bsr_op_t op);
    case (op)
      OP_PRESS: op_sel = SEL_PRESS;
      OP_TEMP: op_sel = SEL_TEMP;
      OP_CAL0: op_sel = SEL_CAL0;
      OP_CAL1: op_sel = SEL_CAL1;
      OP_CAL2: op_sel = SEL_CAL2;
      default: op_sel = SEL_CAL3;
    endcase
  endfunction
endpackage
`default_nettype wire

/* File: include/bsr_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface bsr_link_if;
  logic sclk;
  logic din;
  logic dout;
  modport host (
    output sclk,
    output din,
    input dout
  );
  modport dev (
    input sclk,
    input din,
    output dout
  );
endinterface
`default_nettype wire

/* File: logic/bsr_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module bsr_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_r;
  logic [AW:0] rd_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire empty = (wr_r == rd_r);
  wire full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);

  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_r[AW-1:0]];

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_r[AW-1:0]] <= in_data;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_r <= '0;
      rd_r <= '0;
    end
    else
    begin
      wr_r <= wr_r + (AW+1)'(push);
      rd_r <= rd_r + (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

/* File: logic/bsr_dev.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - sample din, launch dout on sclk rise
// - host shifts and samples on falling edge
// - only host drives sclk, starts transactions
// - output data chosen by last instruction
// - dout also shows conversion status
// - pressure, temperature, four calibration, reset
// - frame opens with three high bits
// - frame closes with three low bits
// - four-bit selection field between them
// - dout rises during last stop bit
// - host gives two clocks, then holds low
// - dout falls when conversion ends
// - seventeen clocks shift out sixteen bits
// - readout survives sclk pauses
// - host reads result before next conversion
// - reset pattern recognised in any state
// - host ignores dout during reset pattern
// - host may reset before each conversion
// - results are raw sixteen-bit values
// - sixty-four calibration bits, four words
// - converter clock may stop while idle
module bsr_dev #(
  parameter int unsigned CONV_CYCLES_P = bsr_pkg::CONV_CYCLES,
  parameter logic [bsr_pkg::CALIB_BITS-1:0] CALIB_DATA = bsr_pkg::CALIB_DEFAULT
) (
  input wire logic clk,
  input wire logic rst,
  bsr_link_if.dev lnk,
  input wire logic [bsr_pkg::WORD_BITS-1:0] pressure_result,
  input wire logic [bsr_pkg::WORD_BITS-1:0] temperature_result,
  input wire logic conv_clk_run,
  output logic conv_busy
);
  import bsr_pkg::*;

  typedef enum logic [5:0] {
    D_IDLE = 6'h01,
    D_SEL = 6'h02,
    D_STOP = 6'h04,
    D_ACK = 6'h08,
    D_CONV = 6'h10,
    D_READ = 6'h20
  } bsr_dst_t;

  logic sclk_m_r;
  logic sclk_s_r;
  logic sclk_d_r;
  logic din_m_r;
  logic din_s_r;
  logic run_m_r;
  logic run_s_r;
  bsr_dst_t st_r;
  bsr_dst_t st_nxt;
  logic [BCNT_W-1:0] bcnt_r;
  logic [BCNT_W-1:0] bcnt_nxt;
  logic [SEL_BITS-1:0] sel_r;
  logic [SEL_BITS-1:0] sel_nxt;
  logic [RESET_BITS-1:0] hist_r;
  logic [CONV_W-1:0] conv_r;
  logic [CONV_W-1:0] conv_nxt;
  logic [WORD_BITS-1:0] sh_r;
  logic [WORD_BITS-1:0] sh_nxt;
  logic dout_r;
  logic dout_nxt;
  logic busy_r;
  logic busy_nxt;
  logic [WORD_BITS-1:0] cal_words [CAL_WORDS];

  // the converter only advances while its clock runs, so a stopped clock stalls but never corrupts
  wire rise = sclk_s_r && !sclk_d_r;
  wire [RESET_BITS-1:0] hist_shift = {hist_r[RESET_BITS-2:0], din_s_r};
  wire reset_hit = rise && (hist_shift == RESET_PATTERN);
  wire conv_sel = sel_is_conv(sel_r);
  wire cal_sel = sel_is_cal(sel_r);
  wire [WORD_BITS-1:0] cal_word = cal_words[sel_cal_index(sel_r)];
  wire [WORD_BITS-1:0] raw_result = (sel_r == SEL_PRESS) ? pressure_result : temperature_result;
  wire conv_tick = run_s_r && (conv_r != '0);
  wire conv_done = (conv_r == '0);

  genvar g;
  generate
    for (g = 0; g < CAL_WORDS; g++)
    begin : g_cal
      assign cal_words[g] = CALIB_DATA[CALIB_BITS-1-g*WORD_BITS -: WORD_BITS];
    end
  endgenerate

  assign lnk.dout = dout_r;
  assign conv_busy = busy_r;

  always_comb
  begin
    st_nxt = st_r;
    bcnt_nxt = bcnt_r;
    sel_nxt = sel_r;
    conv_nxt = conv_r;
    sh_nxt = sh_r;
    dout_nxt = dout_r;
    busy_nxt = busy_r;
    if ((st_r == D_ACK || st_r == D_CONV) && conv_tick)
      conv_nxt = conv_r - CONV_W'(1);
    if (st_r == D_CONV && conv_done)
    begin
      sh_nxt = raw_result;
      dout_nxt = 1'b0;
      busy_nxt = 1'b0;
      bcnt_nxt = '0;
      st_nxt = D_READ;
    end
    if (rise)
    begin
      case (st_r)
        D_IDLE:
        begin
          if (din_s_r)
          begin
            bcnt_nxt = bcnt_r + BCNT_W'(1);
            if (bcnt_r == START_LAST)
            begin
              bcnt_nxt = '0;
              st_nxt = D_SEL;
            end
          end
          else
            bcnt_nxt = '0;
        end
        D_SEL:
        begin
          sel_nxt = {sel_r[SEL_BITS-2:0], din_s_r};
          bcnt_nxt = bcnt_r + BCNT_W'(1);
          if (bcnt_r == SEL_LAST)
          begin
            bcnt_nxt = '0;
            st_nxt = D_STOP;
          end
        end
        D_STOP:
        begin
          bcnt_nxt = bcnt_r + BCNT_W'(1);
          if (din_s_r)
          begin
            // a high stop bit means a broken frame; hunt for a new start
            bcnt_nxt = '0;
            st_nxt = D_IDLE;
          end
          else if (bcnt_r == STOP_LAST)
          begin
            bcnt_nxt = '0;
            if (conv_sel)
            begin
              dout_nxt = 1'b1;
              busy_nxt = 1'b1;
              conv_nxt = CONV_W'(CONV_CYCLES_P);
              st_nxt = D_ACK;
            end
            else if (cal_sel)
            begin
              sh_nxt = cal_word;
              st_nxt = D_READ;
            end
            else
              st_nxt = D_IDLE;
          end
        end
        D_ACK:
        begin
          bcnt_nxt = bcnt_r + BCNT_W'(1);
          if (bcnt_r == ACK_LAST)
          begin
            bcnt_nxt = '0;
            st_nxt = D_CONV;
          end
        end
        D_READ:
        begin
          // state only moves on edges, so an sclk pause just holds the word
          dout_nxt = sh_r[WORD_BITS-1];
          sh_nxt = {sh_r[WORD_BITS-2:0], 1'b0};
          bcnt_nxt = bcnt_r + BCNT_W'(1);
          if (bcnt_r == READ_LAST)
          begin
            dout_nxt = 1'b0;
            bcnt_nxt = '0;
            st_nxt = D_IDLE;
          end
        end
        default:
        begin
          st_nxt = st_r;
        end
      endcase
    end
    if (reset_hit)
    begin
      st_nxt = D_IDLE;
      bcnt_nxt = '0;
      dout_nxt = 1'b0;
      busy_nxt = 1'b0;
      conv_nxt = '0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sclk_m_r <= 1'b0;
      sclk_s_r <= 1'b0;
      sclk_d_r <= 1'b0;
      din_m_r <= 1'b0;
      din_s_r <= 1'b0;
      run_m_r <= 1'b0;
      run_s_r <= 1'b0;
    end
    else
    begin
      sclk_m_r <= lnk.sclk;
      sclk_s_r <= sclk_m_r;
      sclk_d_r <= sclk_s_r;
      din_m_r <= lnk.din;
      din_s_r <= din_m_r;
      run_m_r <= conv_clk_run;
      run_s_r <= run_m_r;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= D_IDLE;
      bcnt_r <= '0;
      sel_r <= '0;
      hist_r <= '0;
      conv_r <= '0;
      sh_r <= '0;
      dout_r <= 1'b0;
      busy_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      bcnt_r <= bcnt_nxt;
      sel_r <= sel_nxt;
      if (rise)
        hist_r <= hist_shift;
      conv_r <= conv_nxt;
      sh_r <= sh_nxt;
      dout_r <= dout_nxt;
      busy_r <= busy_nxt;
    end
  end
endmodule
`default_nettype wire

/* File: logic/bsr_host.sv */
`timescale 1ns/1ps
`default_nettype none
module bsr_host (
  input wire logic clk,
  input wire logic rst,
  bsr_link_if.host lnk,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire bsr_pkg::bsr_op_t cmd_op,
  output logic res_valid,
  input wire logic res_ready,
  output logic [bsr_pkg::WORD_BITS-1:0] res_data
);
  import bsr_pkg::*;

  typedef enum logic [4:0] {
    H_IDLE = 5'h01,
    H_CMD = 5'h02,
    H_WAIT = 5'h04,
    H_READ = 5'h08,
    H_PUSH = 5'h10
  } bsr_hst_t;

  localparam logic [3:0] PH_RISE = 4'(SCLK_HALF_CYCLES - 1);
  localparam logic [3:0] PH_END = 4'(2 * SCLK_HALF_CYCLES - 1);

  logic dout_m_r;
  logic dout_s_r;
  bsr_hst_t st_r;
  bsr_hst_t st_nxt;
  logic [3:0] ph_r;
  logic [BCNT_W-1:0] left_r;
  logic [RESET_BITS-1:0] tx_r;
  logic [WORD_BITS-1:0] rx_r;
  logic sclk_r;
  logic din_r;
  logic conv_r;
  logic rst_op_r;
  logic ready_r;
  logic fifo_ready;

  wire accept = cmd_valid && ready_r;
  wire active = (st_r == H_CMD) || (st_r == H_READ);
  wire clk_end = active && (ph_r == PH_END);
  wire last_clk = clk_end && (left_r == BCNT_W'(1));
  wire is_conv_op = (cmd_op == OP_PRESS) || (cmd_op == OP_TEMP);
  wire [RESET_BITS-1:0] frame = (cmd_op == OP_RESET) ? RESET_PATTERN :
    {START_FIELD, op_sel(cmd_op), STOP_FIELD, {(RESET_BITS-START_BITS-SEL_BITS-STOP_BITS){1'b0}}};
  wire push = (st_r == H_PUSH);

  assign lnk.sclk = sclk_r;
  assign lnk.din = din_r;
  assign cmd_ready = ready_r;

  always_comb
  begin
    st_nxt = st_r;
    if (accept)
      st_nxt = H_CMD;
    else if (st_r == H_CMD && last_clk)
    begin
      // dout is never sampled in this state, so reset-pattern glitches are harmless
      if (rst_op_r)
        st_nxt = H_IDLE;
      else if (conv_r)
        st_nxt = H_WAIT;
      else
        st_nxt = H_READ;
    end
    else if (st_r == H_WAIT && !dout_s_r)
      st_nxt = H_READ;
    else if (st_r == H_READ && last_clk)
      st_nxt = H_PUSH;
    else if (push)
      st_nxt = H_IDLE;
  end

  bsr_fifo #(
    .W(WORD_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(rx_r),
    .out_valid(res_valid),
    .out_ready(res_ready),
    .out_data(res_data)
  );

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dout_m_r <= 1'b0;
      dout_s_r <= 1'b0;
    end
    else
    begin
      dout_m_r <= lnk.dout;
      dout_s_r <= dout_m_r;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= H_IDLE;
      ph_r <= '0;
      left_r <= '0;
      tx_r <= '0;
      rx_r <= '0;
      sclk_r <= 1'b0;
      din_r <= 1'b0;
      conv_r <= 1'b0;
      rst_op_r <= 1'b0;
      ready_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      // a full fifo holds off new commands, so no result is ever dropped
      ready_r <= (st_nxt == H_IDLE) && fifo_ready && !push;
      if (accept)
      begin
        tx_r <= frame;
        din_r <= frame[RESET_BITS-1];
        conv_r <= is_conv_op;
        rst_op_r <= (cmd_op == OP_RESET);
        left_r <= (cmd_op == OP_RESET) ? RESET_CLKS : (is_conv_op ? CONV_FRAME_CLKS : FRAME_CLKS);
        ph_r <= '0;
      end
      else if (st_nxt == H_READ && st_r != H_READ)
      begin
        left_r <= READ_CLKS_W;
        ph_r <= '0;
        din_r <= 1'b0;
        // close the last command clock here, or the first read clock merges into it
        sclk_r <= 1'b0;
      end
      else if (active)
      begin
        ph_r <= clk_end ? 4'h0 : ph_r + 4'h1;
        if (ph_r == PH_RISE)
          sclk_r <= 1'b1;
        if (clk_end)
        begin
          sclk_r <= 1'b0;
          tx_r <= {tx_r[RESET_BITS-2:0], 1'b0};
          din_r <= tx_r[RESET_BITS-2];
          left_r <= left_r - BCNT_W'(1);
          if (st_r == H_READ && left_r != BCNT_W'(1))
            rx_r <= {rx_r[WORD_BITS-2:0], dout_s_r};
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/bsr_props.sv */
`timescale 1ns/1ps
`default_nettype none
module bsr_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  din_quiet_high_a: assert property ($changed(din) |-> !sclk)
    else $error("command line moved while serial clock high");
  sclk_high_len_a: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("serial clock high phase not eight cycles");
  sclk_low_len_a: assert property ($fell(sclk) |-> !sclk [*8])
    else $error("serial clock low phase shorter than eight cycles");
  dout_rise_high_a: assert property ($rose(dout) |-> sclk)
    else $error("data output rose outside a high phase");
  dout_low_fall_a: assert property ($changed(dout) && !sclk |-> $fell(dout))
    else $error("data output rose while serial clock held low");
  // the host samples late in the high phase, so the bit must be settled by then
  dout_settled_a: assert property ($rose(sclk) |-> ##6 $stable(dout) [*2])
    else $error("data output not settled late in high phase");
  sclk_idle_rst_a: assert property ($fell(rst) |-> !sclk [*8])
    else $error("serial clock not idle low after reset");
  dout_idle_rst_a: assert property ($fell(rst) |-> !dout [*8])
    else $error("data output not low after reset");

  cover property ($fell(dout) && !sclk);
  cover property ($rose(dout));
  cover property ($rose(sclk) && din);
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bsr_pkg::*;
  localparam logic [CALIB_BITS-1:0] CAL = 64'hfedc_ba98_7654_3210;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic res_ready = 1'b0;
  logic run = 1'b1;
  logic run_b = 1'b0;
  logic [WORD_BITS-1:0] pv = 16'h8a3c;
  logic [WORD_BITS-1:0] tv = 16'h5e71;
  bsr_op_t cmd_op = OP_CAL0;
  logic cmd_ready;
  logic res_valid;
  logic busy;
  logic busy_b;
  logic [WORD_BITS-1:0] res_data;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;

  bsr_link_if lnk ();
  bsr_link_if lnk_b ();

  always #50 clk = ~clk;

  bsr_dev #(.CONV_CYCLES_P(50), .CALIB_DATA(CAL)) i_bsr_dev (.clk(clk), .rst(rst), .lnk(lnk.dev),
    .pressure_result(pv), .temperature_result(tv), .conv_clk_run(run), .conv_busy(busy));
  bsr_host i_bsr_host (.clk(clk), .rst(rst), .lnk(lnk.host), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data));
  // second device faces the bench directly so that host faults can be staged
  bsr_dev #(.CONV_CYCLES_P(50), .CALIB_DATA(CAL)) i_bsr_dev_b (.clk(clk), .rst(rst), .lnk(lnk_b.dev),
    .pressure_result(pv), .temperature_result(tv), .conv_clk_run(run_b), .conv_busy(busy_b));
  bsr_props i_bsr_props (.clk(clk), .rst(rst), .sclk(lnk.sclk), .din(lnk.din), .dout(lnk.dout));

  task automatic wrap_up();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      failures++;
      wrap_up();
    end
  end

  task automatic check(input logic [WORD_BITS-1:0] seen, input logic [WORD_BITS-1:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [WORD_BITS-1:0] cal_word(input int i);
    cal_word = CAL[CALIB_BITS-1-WORD_BITS*i -: WORD_BITS];
  endfunction

  // the leading delay lets a ready drop from the previous accept land first
  task automatic issue(input bsr_op_t op);
    #1;
    while (cmd_ready !== 1'b1)
    begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask

  task automatic pop(input logic [WORD_BITS-1:0] exp);
    #1;
    while (res_valid !== 1'b1)
    begin
      @(posedge clk);
      #1;
    end
    check(res_data, exp);
    @(posedge clk);
    res_ready <= 1'b1;
    @(posedge clk);
    res_ready <= 1'b0;
  endtask

  task automatic t_fifo();
    for (int i = 0; i < FIFO_DEPTH; i++)
      issue(bsr_op_t'(OP_CAL0 + 3'(i % CAL_WORDS)));
    repeat (600) @(posedge clk);
    #1;
    check(16'(cmd_ready), 16'h0);
    for (int i = 0; i < FIFO_DEPTH; i++)
      pop(cal_word(i % CAL_WORDS));
    #1;
    check(16'(res_valid), 16'h0);
  endtask

  task automatic t_conv();
    @(posedge clk);
    run <= 1'b0;
    repeat (50) @(posedge clk);
    run <= 1'b1;
    issue(OP_PRESS);
    // converter held off across the conversion: it must stall, not finish
    @(posedge clk);
    run <= 1'b0;
    repeat (400) @(posedge clk);
    #1;
    check(16'(busy), 16'h1);
    check(16'(lnk.dout), 16'h1);
    check(16'(res_valid), 16'h0);
    @(posedge clk);
    run <= 1'b1;
    pop(pv);
    check(16'(busy), 16'h0);
    issue(OP_TEMP);
    pop(tv);
  endtask

  task automatic t_reset();
    issue(OP_RESET);
    issue(OP_CAL3);
    pop(cal_word(3));
  endtask

  task automatic bit_b(input logic b);
    @(posedge clk);
    lnk_b.sclk <= 1'b0;
    lnk_b.din <= b;
    repeat (4) @(posedge clk);
    lnk_b.sclk <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  task automatic send_b(input logic [RESET_BITS-1:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
      bit_b(v[i]);
    @(posedge clk);
    lnk_b.sclk <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
  endtask

  // bits are taken late in the high phase; a long hold mid-word must not lose the position
  task automatic read_b(output logic [WORD_BITS-1:0] w);
    for (int i = WORD_BITS - 1; i >= 0; i--)
    begin
      bit_b(1'b0);
      repeat (3) @(posedge clk);
      #1;
      w[i] = lnk_b.dout;
      if (i == WORD_BITS / 2)
        repeat (40) @(posedge clk);
    end
    send_b(21'h0, 1);
  endtask

  task automatic t_fault();
    logic [WORD_BITS-1:0] w;
    send_b(21'({START_FIELD, SEL_PRESS, 3'h4}), 10);
    check(16'(lnk_b.dout), 16'h0);
    check(16'(busy_b), 16'h0);
    send_b(21'({START_FIELD, 4'h0, STOP_FIELD}), 10);
    check(16'(lnk_b.dout), 16'h0);
    check(16'(busy_b), 16'h0);
    send_b(21'({START_FIELD, SEL_CAL1, STOP_FIELD}), 10);
    read_b(w);
    check(w, cal_word(1));
    check(16'(lnk_b.dout), 16'h0);
    send_b(21'({START_FIELD, SEL_PRESS, STOP_FIELD}), 10);
    check(16'(lnk_b.dout), 16'h1);
    send_b(21'h0, ACK_CLKS);
    check(16'(lnk_b.dout), 16'h1);
    check(16'(busy_b), 16'h1);
    // the converter clock is held off, so only the reset pattern can end this
    send_b(RESET_PATTERN, RESET_BITS);
    check(16'(lnk_b.dout), 16'h0);
    check(16'(busy_b), 16'h0);
  endtask

  initial
  begin
    lnk_b.sclk = 1'b0;
    lnk_b.din = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_fifo();
    t_conv();
    t_reset();
    t_fault();
    wrap_up();
  end
endmodule
`default_nettype wire
